//--- hdl/sadc_port.sv
// Contract
// - A conversion lasts exactly 44 conversion-clock periods.
// - Tenth falling transfer edge starts conversion of the latched channel.
// - Select falling presents previous result MSB without any transfer edge.
// - Nine lower result bits shift out on first nine falling edges, MSB first.
// - After select falls, control inputs ignored for three conversion periods.
// - Twelve-way selector: eleven external inputs or self-test voltage.
// - Sample and hold runs automatically within each transfer.
// - Address shifts in while result shifts out; output is three-state.
// - Address bits captured on rising transfer-clock edges.
`timescale 1ns/10ps
`include "sadc_regs.svh"
module sadc_port (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input sadc_pkg::sadc_pins_s pins_i,
	input wire logic cmp_i,
	output sadc_pkg::sadc_dout_s serial_o,
	output sadc_pkg::sadc_chsel_t chan_sel_o,
	output logic sample_o,
	output sadc_pkg::sadc_result_t dac_code_o,
	output logic busy_o
);
	import sadc_pkg::*;

	// ************************************
	// Pin synchronisation and edges
	// ************************************
	sadc_pins_s pins_s;
	logic cmp_s;
	logic cs_d;
	logic io_d;
	logic sys_d;

	sadc_sync #(
		.W(5),
		.RST_VAL(`SADC_PIN_RST)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.async_i({pins_i, cmp_i}),
		.sync_o({pins_s, cmp_s})
	);

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cs_d <= 1'b1;
			io_d <= 1'b0;
			sys_d <= 1'b0;
		end
		else if (ce_i)
		begin
			cs_d <= pins_s.cs_n;
			io_d <= pins_s.io_clk;
			sys_d <= pins_s.conv_clk;
		end
	end

	logic cs_fall;
	logic io_rise;
	logic io_fall;
	logic sys_rise;

	assign cs_fall = cs_d && !pins_s.cs_n;
	assign io_rise = !io_d && pins_s.io_clk;
	assign io_fall = io_d && !pins_s.io_clk;
	assign sys_rise = !sys_d && pins_s.conv_clk;

	// ************************************
	// Frame sequencing
	// ************************************
	sadc_frame_e fr_st;
	sadc_conv_e cv_st;
	logic [1:0] guard_cnt;
	logic [2:0] rise_cnt;
	logic [3:0] fall_cnt;
	logic load;
	logic addr_rise;
	logic data_fall;
	logic tenth_fall;
	logic conv_start;

	assign load = cs_fall && (fr_st == FR_IDLE);
	assign addr_rise = io_rise && !pins_s.cs_n && (fr_st == FR_XFER)
		&& (rise_cnt < `SADC_ADDR_EDGES);
	assign data_fall = io_fall && !pins_s.cs_n && (fr_st == FR_XFER)
		&& (fall_cnt < `SADC_SHIFT_EDGES);
	assign tenth_fall = io_fall && !pins_s.cs_n && (fr_st == FR_XFER)
		&& (fall_cnt == `SADC_SHIFT_EDGES);
	assign conv_start = tenth_fall && (cv_st == CV_IDLE);

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			fr_st <= FR_IDLE;
			guard_cnt <= '0;
			rise_cnt <= '0;
			fall_cnt <= '0;
		end
		else if (ce_i)
		begin
			if (pins_s.cs_n)
			begin
				fr_st <= FR_IDLE;
			end
			else
			begin
				case (fr_st)
					FR_IDLE:
					begin
						if (cs_fall)
						begin
							fr_st <= FR_GUARD;
							guard_cnt <= '0;
							rise_cnt <= '0;
							fall_cnt <= '0;
						end
					end
					FR_GUARD:
					begin
						if (sys_rise)
						begin
							guard_cnt <= guard_cnt + 1'b1;
							if (guard_cnt == `SADC_GUARD_PERIODS - 2'h1)
							begin
								fr_st <= FR_XFER;
							end
						end
					end
					FR_XFER:
					begin
						if (addr_rise)
						begin
							rise_cnt <= rise_cnt + 1'b1;
						end
						if (data_fall)
						begin
							fall_cnt <= fall_cnt + 1'b1;
						end
						if (tenth_fall)
						begin
							fr_st <= FR_WAIT;
						end
					end
					FR_WAIT: fr_st <= FR_WAIT;
					default: fr_st <= FR_IDLE;
				endcase
			end
		end
	end

	// ************************************
	// Result buffer and serial output
	// ************************************
	sadc_result_t sar_code;
	sadc_result_t held;
	sadc_result_t shifter;
	sadc_result_t buf_data;
	logic buf_in_ready;
	logic buf_out_valid;
	logic pop;

	assign pop = load && buf_out_valid;

	// Two entries let a finished result wait while a frame is still reading
	sadc_buf #(
		.W(`SADC_RES_W),
		.DEPTH(`SADC_BUF_DEPTH)
	) u_buf (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.in_valid_i(cv_st == CV_PUSH),
		.in_ready_o(buf_in_ready),
		.in_data_i(sar_code),
		.out_valid_o(buf_out_valid),
		.out_ready_i(pop),
		.out_data_o(buf_data)
	);

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			held <= '0;
			shifter <= '0;
			serial_o <= '0;
		end
		else if (ce_i)
		begin
			if (pins_s.cs_n)
			begin
				serial_o.oe <= 1'b0;
			end
			else if (load)
			begin
				held <= buf_out_valid ? buf_data : held;
				shifter <= buf_out_valid ? buf_data : held;
				serial_o.dout <= buf_out_valid ? buf_data[`SADC_RES_W-1] : held[`SADC_RES_W-1];
				serial_o.oe <= 1'b1;
			end
			else if (data_fall)
			begin
				shifter <= {shifter[`SADC_RES_W-2:0], 1'b0};
				serial_o.dout <= shifter[`SADC_RES_W-2];
			end
		end
	end

	// ************************************
	// Channel address and selector
	// ************************************
	sadc_addr_t addr_sh;
	sadc_addr_t chan_latch;
	sadc_addr_t sar_chan;

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			addr_sh <= '0;
			chan_latch <= '0;
		end
		else if (ce_i && addr_rise)
		begin
			addr_sh <= {addr_sh[`SADC_ADDR_W-2:0], pins_s.addr};
			if (rise_cnt == `SADC_ADDR_EDGES - 3'h1)
			begin
				chan_latch <= {addr_sh[`SADC_ADDR_W-2:0], pins_s.addr};
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			chan_sel_o <= sadc_chsel_t'(1);
			sample_o <= 1'b0;
		end
		else if (ce_i)
		begin
			chan_sel_o <= '0;
			if (chan_latch >= `SADC_SELFTEST_CH)
			begin
				chan_sel_o[`SADC_SELFTEST_CH] <= 1'b1;
			end
			else
			begin
				chan_sel_o[chan_latch] <= 1'b1;
			end
			if (tenth_fall)
			begin
				sample_o <= 1'b0;
			end
			else if (addr_rise && rise_cnt == `SADC_ADDR_EDGES - 3'h1)
			begin
				sample_o <= 1'b1;
			end
		end
	end

	// ************************************
	// Successive approximation
	// ************************************
	logic [5:0] cv_cnt;
	sadc_result_t trial;

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cv_st <= CV_IDLE;
			cv_cnt <= '0;
			trial <= '0;
			sar_code <= '0;
			sar_chan <= '0;
		end
		else if (ce_i)
		begin
			case (cv_st)
				CV_IDLE:
				begin
					if (conv_start)
					begin
						cv_st <= CV_RUN;
						cv_cnt <= '0;
						trial <= `SADC_SAR_MSB;
						sar_code <= `SADC_SAR_MSB;
						sar_chan <= chan_latch;
					end
				end
				CV_RUN:
				begin
					if (sys_rise)
					begin
						cv_cnt <= cv_cnt + 1'b1;
						if (cv_cnt[1:0] == 2'h3 && cv_cnt < `SADC_BIT_PERIODS)
						begin
							sar_code <= (cmp_s ? sar_code : sar_code & ~trial) | (trial >> 1);
							trial <= trial >> 1;
						end
						if (cv_cnt == `SADC_CONV_LAST)
						begin
							cv_st <= CV_PUSH;
						end
					end
				end
				// Stall here rather than drop a result
				CV_PUSH:
				begin
					if (buf_in_ready)
					begin
						cv_st <= CV_IDLE;
					end
				end
				default: cv_st <= CV_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			dac_code_o <= '0;
			busy_o <= 1'b0;
		end
		else if (ce_i)
		begin
			dac_code_o <= sar_code;
			busy_o <= conv_start || (cv_st == CV_RUN)
				|| (cv_st == CV_PUSH && !buf_in_ready);
		end
	end

	// ************************************
	// Checks
	// ************************************
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_tenth;
		ce_i && tenth_fall;
	endsequence

	sequence s_load;
		ce_i && load;
	endsequence

	sequence s_shift;
		ce_i && data_fall;
	endsequence

	a_conv_length: assert property (cv_st == CV_PUSH |-> cv_cnt == `SADC_CONV_PERIODS)
		else $error("conversion not 44 periods");
	a_start_tenth: assert property (s_tenth ##0 cv_st == CV_IDLE |=>
		cv_st == CV_RUN && sar_chan == $past(chan_latch))
		else $error("conversion not started on tenth edge");
	a_msb_first: assert property (s_load |=>
		serial_o.oe && serial_o.dout == shifter[`SADC_RES_W-1])
		else $error("msb not presented at select");
	a_shift_out: assert property (s_shift |=>
		serial_o.dout == $past(shifter[`SADC_RES_W-2]))
		else $error("wrong bit shifted out");
	a_guard_ignore: assert property (ce_i && fr_st == FR_GUARD |=>
		$stable(rise_cnt) && $stable(fall_cnt) && $stable(addr_sh))
		else $error("control input taken during guard");
	a_mux_onehot: assert property ($onehot(chan_sel_o))
		else $error("selector not one-hot");
	a_auto_sample: assert property (s_tenth |=> !sample_o)
		else $error("sample not released at start");
	a_addr_capture: assert property (ce_i && addr_rise |=>
		addr_sh[0] == $past(pins_s.addr))
		else $error("address bit not captured");
	a_addr_latch: assert property (ce_i && addr_rise && rise_cnt == 3'h3 |=>
		chan_latch == $past(addr_sh << 1 | pins_s.addr))
		else $error("address not latched after fourth bit");
	a_cs_high_hiz: assert property (ce_i && pins_s.cs_n |=> !serial_o.oe)
		else $error("output driven with select high");
	a_duplex_oe: assert property (s_shift ##1 !pins_s.cs_n |-> serial_o.oe)
		else $error("output released during shift");
endmodule

//--- hdl/sadc_regs.svh
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// ************************************
// Widths
// ************************************
`define SADC_RES_W 10
`define SADC_ADDR_W 4
`define SADC_CH_N 12
`define SADC_BUF_DEPTH 2

// ************************************
// Codes and counts
// ************************************
`define SADC_SELFTEST_CH 4'hb
`define SADC_CONV_PERIODS 6'h2c
`define SADC_CONV_LAST 6'h2b
`define SADC_BIT_PERIODS 6'h28
`define SADC_GUARD_PERIODS 2'h3
`define SADC_ADDR_EDGES 3'h4
`define SADC_SHIFT_EDGES 4'h9
`define SADC_SAR_MSB 10'h200
`define SADC_PIN_RST 5'h10

`endif

//--- hdl/sadc_pkg.sv
package sadc_pkg;
`include "sadc_regs.svh"

	typedef logic [`SADC_RES_W-1:0] sadc_result_t;
	typedef logic [`SADC_ADDR_W-1:0] sadc_addr_t;
	typedef logic [`SADC_CH_N-1:0] sadc_chsel_t;

	// Host pins, all asynchronous to ref_clk_i
	typedef struct packed {
		logic cs_n;
		logic io_clk;
		logic conv_clk;
		logic addr;
	} sadc_pins_s;

	// Three-state serial output
	typedef struct packed {
		logic dout;
		logic oe;
	} sadc_dout_s;

	typedef enum logic [1:0] {FR_IDLE, FR_GUARD, FR_XFER, FR_WAIT} sadc_frame_e;
	typedef enum logic [1:0] {CV_IDLE, CV_RUN, CV_PUSH} sadc_conv_e;

endpackage

//--- hdl/sadc_sync.sv
`timescale 1ns/10ps
module sadc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			meta <= RST_VAL;
			sync_o <= RST_VAL;
		end
		else if (ce_i)
		begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule

//--- hdl/sadc_buf.sv
`timescale 1ns/10ps
module sadc_buf #(
	parameter int W = 10,
	parameter int DEPTH = 2
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_idx;
	logic [AW-1:0] rd_idx;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_idx];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				mem[i] <= '0;
			end
		end
		else if (ce_i && push)
		begin
			mem[wr_idx] <= in_data_i;
		end
	end

	// Index wrap works for any depth, not only powers of two
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
		end
		else if (ce_i)
		begin
			if (push)
			begin
				wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
			end
			if (pop)
			begin
				rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
			end
			case ({push, pop})
				2'b10: count <= count + 1'b1;
				2'b01: count <= count - 1'b1;
				default: count <= count;
			endcase
		end
	end
endmodule

//--- tb/sadc_host_model.sv
`timescale 1ns/10ps
module sadc_host_model (
	input wire logic ref_clk_i,
	input sadc_pkg::sadc_dout_s serial_i,
	output sadc_pkg::sadc_pins_s pins_o
);
	import sadc_pkg::*;
	logic cs_n = 1'b1;
	logic io = 1'b0;
	logic cclk = 1'b0;
	logic ad = 1'b0;
	int cdiv = 0;

	assign pins_o = {cs_n, io, cclk, ad};

	// Released line reads inverted, so a late or missing enable shows up
	logic dline;
	assign dline = serial_i.oe ? serial_i.dout : !serial_i.dout;

	// ************************************
	// Conversion clock
	// ************************************
	// Not slower than transfer clock
	always @(posedge ref_clk_i)
	begin
		if (cdiv == 5)
		begin
			cdiv <= 0;
			cclk <= ~cclk;
		end
		else
			cdiv <= cdiv + 1;
	end

	task automatic wait_ref(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// ************************************
	// One framed transfer
	// ************************************
	task automatic frame(input logic [3:0] a, input bit glitch, input bit early,
		output sadc_result_t got);
		@(posedge ref_clk_i) cs_n <= 1'b0;
		// Noise pulse inside the guard, meant to be ignored
		if (glitch)
		begin
			wait_ref(4);
			io <= 1'b1;
			wait_ref(4);
			io <= 1'b0;
		end
		wait_ref(48);
		got[9] = dline;
		for (int k = 1; k <= 10; k++)
		begin
			ad <= (k <= 4) ? a[4-k] : ~ad;
			wait_ref(10);
			if (k > 1)
				got[10-k] = dline;
			io <= 1'b1;
			wait_ref(10);
			io <= 1'b0;
		end
		// Select high during conversion
		// Raised only after the tenth fall is seen, else no conversion starts
		if (early)
		begin
			wait_ref(8);
			cs_n <= 1'b1;
		end
		wait_ref(46 * 12);
		cs_n <= 1'b1;
		wait_ref(6);
	endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
	import sadc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic cmp_i = 1'b0;
	sadc_pins_s pins;
	sadc_dout_s serial;
	sadc_chsel_t chan_sel;
	sadc_chsel_t hit;
	logic sample;
	logic busy;
	logic smp;
	logic bsy;
	sadc_result_t dac_code;
	sadc_result_t got;
	sadc_result_t exp_res;
	sadc_result_t vin [12];
	logic [3:0] addr;
	logic [3:0] corner [5] = '{4'h0, 4'ha, 4'hb, 4'hf, 4'h5};
	int failures = 0;
	int n_tests = 0;
	integer seed = 32'h3f35230b;

	always #4 ref_clk_i = ~ref_clk_i;

	sadc_port i_dut (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.pins_i(pins),
		.cmp_i(cmp_i),
		.serial_o(serial),
		.chan_sel_o(chan_sel),
		.sample_o(sample),
		.dac_code_o(dac_code),
		.busy_o(busy)
	);

	sadc_host_model i_host (
		.ref_clk_i(ref_clk_i),
		.serial_i(serial),
		.pins_o(pins)
	);

	// ************************************
	// Analog side: selector and comparator
	// ************************************
	always @(posedge ref_clk_i)
	begin
		for (int i = 0; i < 12; i++)
			hit[i] = vin[i] >= dac_code;
		cmp_i <= |(hit & chan_sel);
	end

	function automatic logic [3:0] chan_idx(input logic [3:0] a);
		chan_idx = (a > 4'hb) ? 4'hb : a;
	endfunction

	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] seen);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		$display("Checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ************************************
	// Main sequence
	// ************************************
	initial
	begin
		for (int i = 0; i < 12; i++)
			vin[i] = 10'($random(seed));
		vin[0] = 10'h000;
		vin[10] = 10'h3ff;
		exp_res = '0;
		repeat (10) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		for (int n = 0; n < 16; n++)
		begin
			addr = (n < 5) ? corner[n] : 4'($random(seed));
			fork
				i_host.frame(addr, n == 2, n == 3, got);
				begin
					repeat (150) @(posedge ref_clk_i);
					smp = sample;
					repeat (578) @(posedge ref_clk_i);
					bsy = busy;
				end
			join
			chk("result", 12'(exp_res), 12'(got));
			chk("chan_sel", 12'h001 << chan_idx(addr), chan_sel);
			chk("sample", 12'h001, 12'(smp));
			chk("busy_mid", 12'h001, 12'(bsy));
			chk("busy_end", 12'h000, 12'(busy));
			chk("oe_idle", 12'h000, 12'(serial.oe));
			exp_res = vin[chan_idx(addr)];
		end
		results();
	end

	// Hang guard, well beyond the whole run
	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		failures++;
		$display("Error timeout expected 0 seen 1");
		results();
	end
endmodule
